/* rtl/amp_core.sv */
`timescale 1ns/1ps
module amp_core
  import amp_pkg::*;
#(
  parameter int NUM_AR = 8,
  parameter int NUM_ACC = 4,
  parameter logic [23:0] INT_MEM_TOP = 24'h00_FFFF
)
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic ISSUE_IN,
  input wire logic REPEAT_IN,
  input wire logic [31:0] OPCODE_IN,
  input wire logic [15:0] Y_DATA_IN,
  input wire logic [15:0] COEF_DATA_IN,
  input wire logic [23:0] COEF_ADDR_IN,
  input wire logic [15:0] STATUS_REG_TWO_IN,
  input wire logic [15:0] CIRC_SIZE_LOW_IN,
  input wire logic [15:0] CIRC_SIZE_HIGH_IN,
  input wire logic [15:0] CIRC_START_IN,
  input wire logic SIGN_EXT_MODE_IN,
  input wire logic FRACTIONAL_MODE_IN,
  input wire logic SAT_ON_MULTIPLY_IN,
  input wire logic ROUND_MODE_BIT_IN,
  input wire logic WIDE_OVERFLOW_MODE_IN,
  input wire logic SAT_D_UNIT_IN,
  input wire logic ACC_WR_IN,
  input wire logic [1:0] ACC_WR_SEL_IN,
  input wire logic [39:0] ACC_WR_DATA_IN,
  input wire logic AR_WR_IN,
  input wire logic [2:0] AR_WR_SEL_IN,
  input wire logic [15:0] AR_WR_DATA_IN,
  input wire logic [NUM_ACC-1:0] OVF_CLR_IN,
  input wire logic [1:0] ACC_RD_SEL_IN,
  input wire logic [2:0] AR_RD_SEL_IN,
  output logic [39:0] ACC_RD_OUT,
  output logic [15:0] AR_RD_OUT,
  output logic [NUM_ACC-1:0] ACC_OVERFLOW_FLAG_OUT,
  output logic BUS_ERROR_OUT,
  output logic DONE_OUT,
  output logic MULT_ACTIVE_OUT
);
  ////////////////////////////////////////////////////////////////
  logic [39:0] acc [NUM_ACC];
  logic [15:0] ar [NUM_AR];
  logic [NUM_ACC-1:0] ovf;
  amp_state_type state;
  amp_state_type next_state;

  // Decode fields
  wire [7:0] op = OPCODE_IN[31:24];
  wire is_mpy = (op == OP_MPY);
  wire is_mac = (op == OP_MAC);
  wire is_macs = (op == OP_MACS);
  wire is_mar = (op == OP_MAR);
  wire is_fused = is_mpy | is_mac | is_macs;
  wire legal = is_fused | is_mar;
  wire [2:0] x_reg = is_mar ? OPCODE_IN[23:21] : OPCODE_IN[23:21];
  wire [1:0] x_mod = is_mar ? OPCODE_IN[17:16] : OPCODE_IN[20:19];
  wire mac_off = is_fused & (OPCODE_IN[9:8] == 2'b00);
  wire uns_y = OPCODE_IN[7];
  wire uns_c = OPCODE_IN[6];
  wire [1:0] dst = OPCODE_IN[3:2];
  wire [1:0] src = OPCODE_IN[5:4];
  wire rnd_q = OPCODE_IN[1];
  wire wide_kw = OPCODE_IN[0];
  wire go = ISSUE_IN & (state != AMP_ERR) & legal;

  ////////////////////////////////////////////////////////////////
  // Address update
  wire [15:0] ar_cur = ar[x_reg];
  wire [15:0] step = (x_mod == MOD_POST_INC) ? 16'h0001 :
                     (x_mod == MOD_POST_DEC) ? 16'hFFFF : 16'h0000;
  wire circ_on = STATUS_REG_TWO_IN[x_reg];
  wire [15:0] lin_next = ar_cur + step;
  wire [15:0] circ_len = CIRC_SIZE_LOW_IN;
  wire [15:0] circ_off = ar_cur - CIRC_START_IN;
  wire [15:0] circ_top = (circ_len == 16'h0000) ? 16'h0000 : circ_len - 16'h0001;
  wire [15:0] circ_step = (x_mod == MOD_POST_INC) ?
                          ((circ_off >= circ_top) ? 16'h0000 : circ_off + 16'h0001) :
                          (x_mod == MOD_POST_DEC) ?
                          ((circ_off == 16'h0000) ? circ_top : circ_off - 16'h0001) :
                          circ_off;
  wire [15:0] circ_next = CIRC_START_IN + circ_step;
  wire [15:0] ar_new = circ_on ? circ_next : lin_next;
  wire unused_high = |CIRC_SIZE_HIGH_IN;

  ////////////////////////////////////////////////////////////////
  // Multiplier operand widening
  wire y_sx = ~uns_y & SIGN_EXT_MODE_IN & Y_DATA_IN[15];
  wire c_sx = ~uns_c & SIGN_EXT_MODE_IN & COEF_DATA_IN[15];
  wire signed [16:0] y_op = {y_sx, Y_DATA_IN};
  wire signed [16:0] c_op = {c_sx, COEF_DATA_IN};
  wire signed [33:0] prod_raw = y_op * c_op;
  wire [31:0] prod_shift = FRACTIONAL_MODE_IN ? {prod_raw[30:0], 1'b0} :
                           prod_raw[31:0];
  wire sat_on_multiply_hit = SAT_ON_MULTIPLY_IN & FRACTIONAL_MODE_IN & SIGN_EXT_MODE_IN &
                  (prod_shift == SAT_ON_MULTIPLY_TRIG) & ~uns_y & ~uns_c;
  wire [31:0] prod = sat_on_multiply_hit ? SAT_ON_MULTIPLY_POS : prod_shift;
  wire [39:0] prod_ext = {{8{prod[31]}}, prod};
  wire [39:0] src_val = acc[src];
  wire [39:0] src_shr = {{16{src_val[39]}}, src_val[39:16]};
  wire [39:0] addend = is_mpy ? ACC_RST : is_macs ? src_shr : src_val;
  wire [40:0] sum = {addend[39], addend} + {prod_ext[39], prod_ext};
  wire [40:0] rnd_add = rnd_q ? (ROUND_MODE_BIT_IN ? 41'h0_0000_8000 : 41'h0_0000_8000)
                              : 41'h0;
  wire [40:0] sum_r = sum + rnd_add;
  wire [40:0] sum_c = (rnd_q & ROUND_MODE_BIT_IN & (sum[15:0] == 16'h8000)) ?
                      {sum_r[40:17], 1'b0, 16'h0000} :
                      rnd_q ? {sum_r[40:16], 16'h0000} : sum_r;
  wire wide = WIDE_OVERFLOW_MODE_IN | wide_kw;
  wire ovf40 = sum_c[40] ^ sum_c[39];
  wire ovf32 = ~((sum_c[40:31] == 10'h000) | (sum_c[40:31] == 10'h3FF));
  wire ovf_hit = wide ? ovf40 : ovf32;
  wire neg = sum_c[40];
  wire [39:0] sat_val = wide ? (neg ? SAT40_NEG : SAT40_POS) :
                        (neg ? SAT32_NEG : SAT32_POS);
  wire [39:0] result = (ovf_hit & SAT_D_UNIT_IN) ? sat_val : sum_c[39:0];
  wire coef_ext = is_fused & ~mac_off & (COEF_ADDR_IN > INT_MEM_TOP);
  wire do_mul = go & is_fused & ~mac_off & ~coef_ext;

  ////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_state = AMP_IDLE;
    unique case (state)
      AMP_IDLE, AMP_EXEC:
      begin
        if (ISSUE_IN & legal & coef_ext)
        begin
          next_state = AMP_ERR;
        end
        else if (go)
        begin
          next_state = AMP_EXEC;
        end
      end
      AMP_ERR: next_state = AMP_IDLE;
      default: next_state = AMP_IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      state <= AMP_IDLE;
      DONE_OUT <= 1'b0;
      MULT_ACTIVE_OUT <= 1'b0;
      BUS_ERROR_OUT <= 1'b0;
    end
    else
    begin
      state <= next_state;
      DONE_OUT <= go & ~coef_ext;
      MULT_ACTIVE_OUT <= do_mul;
      BUS_ERROR_OUT <= ISSUE_IN & legal & coef_ext;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_AR; g++)
    begin : g_ar
      always_ff @(posedge CLK_IN or posedge RST_IN)
      begin
        if (RST_IN)
        begin
          ar[g] <= AR_RST;
        end
        else if (go & ~coef_ext & (x_reg == 3'(g)))
        begin
          ar[g] <= ar_new;
        end
        else if (AR_WR_IN & (AR_WR_SEL_IN == 3'(g)))
        begin
          ar[g] <= AR_WR_DATA_IN;
        end
      end
    end
    for (g = 0; g < NUM_ACC; g++)
    begin : g_acc
      always_ff @(posedge CLK_IN or posedge RST_IN)
      begin
        if (RST_IN)
        begin
          acc[g] <= ACC_RST;
          ovf[g] <= 1'b0;
        end
        else
        begin
          if (do_mul & (dst == 2'(g)))
          begin
            acc[g] <= result;
          end
          else if (ACC_WR_IN & (ACC_WR_SEL_IN == 2'(g)))
          begin
            acc[g] <= ACC_WR_DATA_IN;
          end
          if (do_mul & (dst == 2'(g)) & ovf_hit)
          begin
            ovf[g] <= 1'b1;
          end
          else if (OVF_CLR_IN[g])
          begin
            ovf[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      ACC_RD_OUT <= ACC_RST;
      AR_RD_OUT <= AR_RST;
    end
    else
    begin
      ACC_RD_OUT <= acc[ACC_RD_SEL_IN];
      AR_RD_OUT <= ar[AR_RD_SEL_IN];
    end
  end

  assign ACC_OVERFLOW_FLAG_OUT = ovf;

  ////////////////////////////////////////////////////////////////
  // Checks
  chk_one_cycle_done: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (go & ~coef_ext) |=> DONE_OUT)
    else $error("Operation did not finish in one cycle");
  chk_bus_err_blocks: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (ISSUE_IN & legal & coef_ext) |=> (BUS_ERROR_OUT & ~MULT_ACTIVE_OUT))
    else $error("External coefficient not flagged");
  chk_mar_no_mult: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (ISSUE_IN & is_mar) |=> ~MULT_ACTIVE_OUT)
    else $error("Multiplier ran on modify only");
  chk_linear_inc: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (go & ~coef_ext & ~circ_on & (x_mod == MOD_POST_INC) & ~AR_WR_IN) |=>
    (ar[$past(x_reg)] == $past(ar_cur) + 16'h0001))
    else $error("Post increment wrong");
  chk_circ_wrap: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (go & ~coef_ext & circ_on & (x_mod == MOD_POST_INC) & (circ_off == circ_top) &
     (circ_len != 16'h0000)) |=> (ar[$past(x_reg)] == $past(CIRC_START_IN)))
    else $error("Circular wrap wrong");
  chk_ovf_sets_flag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (do_mul & ovf_hit) |=> ACC_OVERFLOW_FLAG_OUT[$past(dst)])
    else $error("Overflow flag not set");
  chk_sat_value: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (do_mul & ovf_hit & SAT_D_UNIT_IN & ~wide & ~neg & ~ACC_WR_IN) |=>
    (acc[$past(dst)] == SAT32_POS))
    else $error("Saturation value wrong");
  chk_mpy_replace: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (do_mul & is_mpy & ~rnd_q & ~ovf_hit & ~ACC_WR_IN) |=>
    (acc[$past(dst)] == $past(prod_ext)))
    else $error("Multiply did not replace accumulator");
  chk_frac_shift: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (FRACTIONAL_MODE_IN & ~sat_on_multiply_hit) |-> (prod[0] == 1'b0))
    else $error("Fractional shift missing");
  cov_mpy: cover property (@(posedge CLK_IN) disable iff (RST_IN) do_mul & is_mpy);
  cov_mac_shift: cover property (@(posedge CLK_IN) disable iff (RST_IN) do_mul & is_macs);
  cov_circ: cover property (@(posedge CLK_IN) disable iff (RST_IN) go & circ_on);
  cov_ovf: cover property (@(posedge CLK_IN) disable iff (RST_IN) do_mul & ovf_hit);
  cov_bus_err: cover property (@(posedge CLK_IN) disable iff (RST_IN) ISSUE_IN & legal & coef_ext);

  ////////////////////////////////////////////////////////////////
  // Issue and address checks

  chk_repeat_accept: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (go & ~coef_ext & REPEAT_IN) |=> DONE_OUT)
    else $error("Repeated issue not accepted");

  chk_mult_flag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (go & is_fused & ~mac_off & ~coef_ext) |=> (MULT_ACTIVE_OUT & DONE_OUT))
    else $error("Fused multiply not done in one cycle");

  chk_mac_idle_ar: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (go & mac_off) |=> (~MULT_ACTIVE_OUT & DONE_OUT))
    else $error("Idle multiplier form misbehaved");

  chk_linear_dec: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (go & ~coef_ext & ~circ_on & (x_mod == MOD_POST_DEC)) |=>
    (ar[$past(x_reg)] == $past(ar_cur) - 16'h0001))
    else $error("Post decrement wrong");

  chk_no_mod_hold: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (go & ~coef_ext & (x_mod == MOD_NONE)) |=>
    (ar[$past(x_reg)] == $past(ar_cur)))
    else $error("Unmodified register changed");

  chk_err_no_update: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (ISSUE_IN & legal & coef_ext & ~AR_WR_IN) |=>
    (ar[$past(x_reg)] == $past(ar_cur)))
    else $error("Register changed on bus error");

  chk_err_ignores_next: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (state == AMP_ERR) |=> ~DONE_OUT)
    else $error("Issue after error accepted");

  chk_illegal_ignored: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (ISSUE_IN & ~legal) |=> (~DONE_OUT & ~BUS_ERROR_OUT))
    else $error("Illegal opcode acted on");

  ////////////////////////////////////////////////////////////////
  // Operand widening checks

  chk_uns_y_zero: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    uns_y |-> ~y_op[16])
    else $error("Unsigned y operand not zero extended");

  chk_uns_c_zero: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    uns_c |-> ~c_op[16])
    else $error("Unsigned coefficient not zero extended");

  chk_signed_ext: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (~uns_y & SIGN_EXT_MODE_IN) |-> (y_op[16] == Y_DATA_IN[15]))
    else $error("Signed y operand not sign extended");

  ////////////////////////////////////////////////////////////////
  // Accumulate, overflow and saturation checks

  chk_mac_sum: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (do_mul & is_mac & ~rnd_q & ~ovf_hit & ~ACC_WR_IN) |=>
    (acc[$past(dst)] == $past(src_val) + $past(prod_ext)))
    else $error("Accumulate sum wrong");

  chk_macs_sum: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (do_mul & is_macs & ~rnd_q & ~ovf_hit & ~ACC_WR_IN) |=>
    (acc[$past(dst)] == $past(src_shr) + $past(prod_ext)))
    else $error("Shifted accumulate sum wrong");

  chk_wide_kw: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (do_mul & wide_kw) |-> (ovf_hit == ovf40))
    else $error("Wide keyword not honoured");

  chk_sat_neg: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (do_mul & ovf_hit & SAT_D_UNIT_IN & ~wide & neg & ~ACC_WR_IN) |=>
    (acc[$past(dst)] == SAT32_NEG))
    else $error("Negative saturation value wrong");

  chk_flag_sticky: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (ACC_OVERFLOW_FLAG_OUT[0] & ~OVF_CLR_IN[0]) |=> ACC_OVERFLOW_FLAG_OUT[0])
    else $error("Overflow flag lost without clear");
endmodule

/* rtl/amp_pkg.sv */
// Contract
// - Circular length from low size register only
// - Circular update only when enable bit set
// - All operations accepted under single repeat
// - Post-increment adds one, no memory access
// - Fused update and multiply in one cycle
// - Opcode 10000010 decodes multiply-plus-modify
// - Opcode 10000011 decodes multiply-accumulate-plus-modify
// - Aux update uses x operand addressing field
// - Multiplier inputs y and coefficient, 17 bits
// - Unsigned qualifier zero-extends input
// - Otherwise extend by sign-extension mode
// - Fractional mode shifts product left one
// - Multiply overflow saturation by control bit
// - Product sign-extended from 32 to 40
// - Plain accumulate adds source accumulator
// - Shifted accumulate uses source arithmetic-shifted sixteen
// - Rounding only with qualifier, per mode
// - Overflow width per mode, sets flag
// - Saturate on overflow only when enabled
// - Wide keyword forces wide mode locally
// - Coefficient external address raises bus error
// - Modify-only forms leave multiplier idle
package amp_pkg;
  localparam logic [7:0] OP_MPY = 8'h82;
  localparam logic [7:0] OP_MAC = 8'h83;
  localparam logic [7:0] OP_MACS = 8'h84;
  localparam logic [7:0] OP_MAR = 8'hB4;
  localparam int ACC_W = 40;
  localparam int AR_W = 16;
  localparam int EXT_W = 17;
  localparam int RND_BIT = 15;
  localparam logic [1:0] MOD_POST_INC = 2'h1;
  localparam logic [1:0] MOD_POST_DEC = 2'h2;
  localparam logic [1:0] MOD_NONE = 2'h0;
  localparam logic [39:0] ACC_RST = 40'h00_0000_0000;
  localparam logic [15:0] AR_RST = 16'h0000;
  localparam logic [39:0] SAT32_POS = 40'h00_7FFF_FFFF;
  localparam logic [39:0] SAT32_NEG = 40'hFF_8000_0000;
  localparam logic [39:0] SAT40_POS = 40'h7F_FFFF_FFFF;
  localparam logic [39:0] SAT40_NEG = 40'h80_0000_0000;
  localparam logic [31:0] SAT_ON_MULTIPLY_POS = 32'h7FFF_FFFF;
  localparam logic [31:0] SAT_ON_MULTIPLY_TRIG = 32'h8000_0000;
  typedef enum logic [2:0] {
    AMP_IDLE = 3'b001,
    AMP_EXEC = 3'b010,
    AMP_ERR = 3'b100
  } amp_state_type;
endpackage

/* tb/amp_rdbus_model.sv */
`timescale 1ns/1ps
module amp_rdbus_model
(
  input wire logic clk_in,
  input wire logic [2:0] y_addr_in,
  input wire logic [23:0] coef_addr_in,
  output logic [15:0] y_data_out,
  output logic [15:0] coef_data_out
);
  logic [15:0] mem [0:7] = '{16'h0003, 16'hFFFE, 16'h0000, 16'h0000, 16'h0080, 16'h0100,
    16'h8000, 16'h0000};
  logic [15:0] junk = 16'hA5A5;
  // Coefficient bus reaches internal memory only
  always @(posedge clk_in) junk <= ~junk;
  assign y_data_out = mem[y_addr_in];
  assign coef_data_out = (coef_addr_in > 24'h00_FFFF) ? junk : mem[coef_addr_in[2:0]];
endmodule

/* tb/aux_modify_parallel_mac_bench.sv */
`timescale 1ns/1ps
module aux_modify_parallel_mac_bench import amp_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic iss = 1'b0, rpt = 1'b0, sxm = 1'b0, frc = 1'b0, smu = 1'b0, round_mode_bit = 1'b0;
  logic m40 = 1'b0, sat = 1'b0, accw = 1'b0, arw = 1'b0;
  logic [31:0] opc = 32'h0000_0000;
  logic [2:0] ya = 3'h0, arsel = 3'h0, arrd = 3'h0;
  logic [1:0] accsel = 2'h0, accrd = 2'h0;
  logic [23:0] ca = 24'h00_0000;
  logic [15:0] st2 = 16'h0000;
  logic [39:0] wdat = 40'h00_0000_0000;
  logic [3:0] oclr = 4'h0;
  logic [15:0] yd, cd, aro;
  logic [39:0] acco;
  logic [3:0] ovf;
  logic berr, done, mact;
  int n_fail = 0;
  int checks = 0;
  amp_core i_dut (.CLK_IN(clk), .RST_IN(rst), .ISSUE_IN(iss), .REPEAT_IN(rpt), .OPCODE_IN(opc),
    .Y_DATA_IN(yd), .COEF_DATA_IN(cd), .COEF_ADDR_IN(ca), .STATUS_REG_TWO_IN(st2),
    .CIRC_SIZE_LOW_IN(16'h0004), .CIRC_SIZE_HIGH_IN(16'h0002), .CIRC_START_IN(16'h0100),
    .SIGN_EXT_MODE_IN(sxm), .FRACTIONAL_MODE_IN(frc), .SAT_ON_MULTIPLY_IN(smu),
    .ROUND_MODE_BIT_IN(round_mode_bit), .WIDE_OVERFLOW_MODE_IN(m40), .SAT_D_UNIT_IN(sat),
    .ACC_WR_IN(accw), .ACC_WR_SEL_IN(accsel), .ACC_WR_DATA_IN(wdat), .AR_WR_IN(arw),
    .AR_WR_SEL_IN(arsel), .AR_WR_DATA_IN(wdat[15:0]), .OVF_CLR_IN(oclr), .ACC_RD_SEL_IN(accrd),
    .AR_RD_SEL_IN(arrd), .ACC_RD_OUT(acco), .AR_RD_OUT(aro), .ACC_OVERFLOW_FLAG_OUT(ovf),
    .BUS_ERROR_OUT(berr), .DONE_OUT(done), .MULT_ACTIVE_OUT(mact));
  amp_rdbus_model i_mem (.clk_in(clk), .y_addr_in(ya), .coef_addr_in(ca), .y_data_out(yd),
    .coef_data_out(cd));
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [31:0] mk(input logic [7:0] o, input logic [2:0] a,
      input logic [1:0] m, input logic [1:0] mu, input logic [7:0] lo);
    return (o == OP_MAR) ? {o, a, 2'h0, 1'b0, m, 6'h00, mu, lo} : {o, a, m, 3'h0, 6'h00, mu, lo};
  endfunction
  task automatic op(input logic [31:0] o, input logic [2:0] y, input logic [23:0] c,
      input logic [2:0] ex);
    @(posedge clk);
    iss <= 1'b1;
    opc <= o;
    ya <= y;
    ca <= c;
    @(posedge clk);
    iss <= 1'b0;
    #1;
    chk({37'h0, done, mact, berr}, {37'h0, ex});
  endtask
  task automatic ld(input logic a, input logic [2:0] s, input logic [39:0] d);
    @(posedge clk);
    accw <= a;
    arw <= !a;
    accsel <= s[1:0];
    arsel <= s;
    wdat <= d;
    @(posedge clk);
    accw <= 1'b0;
    arw <= 1'b0;
  endtask
  task automatic rd(input logic a, input logic [2:0] s, input logic [39:0] e);
    @(posedge clk);
    accrd <= s[1:0];
    arrd <= s;
    @(posedge clk);
    #1;
    chk(a ? acco : {24'h00_0000, aro}, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_mpy;
    ld(1'b1, 3'h1, 40'h00_1234_0000);
    ld(1'b0, 3'h2, 40'h00_0000_0201);
    op(mk(OP_MPY, 3'h2, MOD_POST_INC, 2'h3, 8'hC4), 3'h0, 24'h00_0001, 3'b110);
    rd(1'b1, 3'h1, 40'h00_0002_FFFA);
    rd(1'b0, 3'h2, 40'h00_0000_0202);
  endtask
  task automatic t_ext;
    logic [31:0] o;
    o = mk(OP_MPY, 3'h2, MOD_NONE, 2'h3, 8'h04);
    sxm <= 1'b1;
    op(o, 3'h1, 24'h00_0000, 3'b110);
    rd(1'b1, 3'h1, 40'hFF_FFFF_FFFA);
    sxm <= 1'b0;
    op(o, 3'h1, 24'h00_0000, 3'b110);
    rd(1'b1, 3'h1, 40'h00_0002_FFFA);
    sxm <= 1'b1;
    frc <= 1'b1;
    op(o, 3'h1, 24'h00_0000, 3'b110);
    rd(1'b1, 3'h1, 40'hFF_FFFF_FFF4);
    frc <= 1'b0;
  endtask
  task automatic t_mac;
    ld(1'b1, 3'h2, 40'h00_0000_0010);
    op(mk(OP_MAC, 3'h2, MOD_NONE, 2'h3, 8'hEC), 3'h0, 24'h00_0001, 3'b110);
    rd(1'b1, 3'h3, 40'h00_0003_000A);
    ld(1'b1, 3'h0, 40'hFF_FFFE_0000);
    op(mk(OP_MACS, 3'h2, MOD_NONE, 2'h3, 8'hC0), 3'h0, 24'h00_0004, 3'b110);
    rd(1'b1, 3'h0, 40'h00_0000_017E);
  endtask
  task automatic t_ovf;
    for (int i = 0; i < 4; i++)
    begin
      ld(1'b1, 3'h0, 40'h00_7FFF_FFF0);
      sat <= (i > 0);
      m40 <= (i == 3);
      op(mk(OP_MAC, 3'h2, MOD_NONE, 2'h3, {7'h20, i == 2}), 3'h0, 24'h00_0001, 3'b110);
      rd(1'b1, 3'h0, (i == 1) ? 40'h00_7FFF_FFFF : 40'h00_8002_FFEA);
      chk({36'h0, ovf}, {39'h0, i < 2});
      @(posedge clk);
      oclr <= 4'h1;
      @(posedge clk);
      oclr <= 4'h0;
    end
    sat <= 1'b0;
    m40 <= 1'b0;
  endtask
  task automatic t_rnd;
    logic [31:0] o;
    o = mk(OP_MPY, 3'h2, MOD_NONE, 2'h3, 8'hC6);
    op(o, 3'h4, 24'h00_0005, 3'b110);
    rd(1'b1, 3'h1, 40'h00_0001_0000);
    round_mode_bit <= 1'b1;
    op(o, 3'h4, 24'h00_0005, 3'b110);
    rd(1'b1, 3'h1, 40'h00_0000_0000);
    op(mk(OP_MPY, 3'h2, MOD_NONE, 2'h3, 8'hC4), 3'h4, 24'h00_0005, 3'b110);
    rd(1'b1, 3'h1, 40'h00_0000_8000);
    round_mode_bit <= 1'b0;
  endtask
  task automatic t_sat_on_multiply;
    logic [31:0] o;
    o = mk(OP_MPY, 3'h2, MOD_NONE, 2'h3, 8'h04);
    frc <= 1'b1;
    smu <= 1'b1;
    op(o, 3'h6, 24'h00_0006, 3'b110);
    rd(1'b1, 3'h1, 40'h00_7FFF_FFFF);
    smu <= 1'b0;
    op(o, 3'h6, 24'h00_0006, 3'b110);
    rd(1'b1, 3'h1, 40'hFF_8000_0000);
    frc <= 1'b0;
  endtask
  task automatic t_circ;
    st2 <= 16'h0008;
    ld(1'b0, 3'h3, 40'h00_0000_0103);
    op(mk(OP_MAR, 3'h3, MOD_POST_INC, 2'h0, 8'h00), 3'h0, 24'h00_0000, 3'b100);
    rd(1'b0, 3'h3, 40'h00_0000_0100);
    @(posedge clk);
    iss <= 1'b1;
    rpt <= 1'b1;
    repeat (2) @(posedge clk);
    iss <= 1'b0;
    rpt <= 1'b0;
    rd(1'b0, 3'h3, 40'h00_0000_0102);
    st2 <= 16'h0000;
    ld(1'b0, 3'h3, 40'h00_0000_0103);
    op(mk(OP_MAR, 3'h3, MOD_POST_INC, 2'h0, 8'h00), 3'h0, 24'h00_0000, 3'b100);
    rd(1'b0, 3'h3, 40'h00_0000_0104);
    op(mk(OP_MPY, 3'h3, MOD_POST_DEC, 2'h0, 8'h04), 3'h0, 24'h00_0001, 3'b100);
    rd(1'b0, 3'h3, 40'h00_0000_0103);
    rd(1'b1, 3'h1, 40'hFF_8000_0000);
    op(mk(OP_MPY, 3'h3, MOD_POST_INC, 2'h3, 8'h04), 3'h0, 24'h01_0000, 3'b001);
    rd(1'b0, 3'h3, 40'h00_0000_0103);
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({36'h0, ovf}, 40'h00_0000_0000);
    t_mpy;
    t_ext;
    t_mac;
    t_ovf;
    t_rnd;
    t_sat_on_multiply;
    t_circ;
    test_done;
  end
endmodule
